/* File: part_pkg.sv */
package part_pkg;
    localparam logic [7:0] ADDR_DUTY_3      = 8'h73;
    localparam logic [7:0] ADDR_DUTY_2      = 8'h74;
    localparam logic [7:0] ADDR_DUTY_1      = 8'h75;
    localparam logic [7:0] ADDR_DUTY_0      = 8'h76;
    localparam logic [7:0] ADDR_OUT_CONTROL = 8'h77;
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h78;
    localparam logic [7:0] ADDR_COUNT_PORT  = 8'h79;
    localparam logic [7:0] ADDR_RELOAD      = 8'h7a;
    localparam logic [7:0] ADDR_SNAP_CS     = 8'h7b;
    localparam logic [7:0] ADDR_SNAP_1      = 8'h7c;
    localparam logic [7:0] ADDR_SNAP_2      = 8'h7d;
    localparam int CS_CLK_SEL   = 7;
    localparam int CS_DIV_LSB   = 4;
    localparam int CS_RUN       = 3;
    localparam int CS_FORCE     = 2;
    localparam int CS_OVF_IE    = 1;
    localparam int CS_OVF_FLAG  = 0;
    localparam int SC_EDGE_LSB  = 4;
    localparam int SC_IE_LSB    = 2;
    localparam int SC_FLAG_LSB  = 0;
    localparam int OC_EN_LSB    = 4;
    localparam int OC_INV_LSB   = 0;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [7:0] COUNT_TOP   = 8'hff;
endpackage

/* File: part_prescaler.sv */
`timescale 1ns/100ps
// Divides the selected tick source by 2**sel; clear restarts the division.
module part_prescaler (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       tick_in,
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [2:0] sel,
    output logic            tick_out
);
    typedef struct packed {
        logic [6:0] cnt;
    } part_pre_type;
    part_pre_type st_r;
    part_pre_type st_nxt;
    logic [6:0]   mask;

    always_comb begin
        mask = 7'(({7'h00, 1'b1} << sel) - 8'h01);
        st_nxt = st_r;
        tick_out = 1'b0;
        if (clear) begin
            st_nxt.cnt = 7'h00;
        end else if (run && tick_in) begin
            if ((st_r.cnt & mask) == mask) begin
                st_nxt.cnt = 7'h00;
                tick_out = 1'b1; // [RULE_20]
            end else begin
                st_nxt.cnt = 7'(st_r.cnt + 7'h01);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    AST_DIV_ONE: assert property (@(posedge clock) disable iff (!rst_n)
        (sel == 3'd0 && run && tick_in && !clear) |-> tick_out) // [RULE_20]
        else $error("Prescaler with ratio one missed a tick");
endmodule

/* File: part_edge_sync.sv */
`timescale 1ns/100ps
// Two-flop synchroniser plus edge detect on the second stage.
module part_edge_sync (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } part_sync_type;
    part_sync_type st_r;
    part_sync_type st_nxt;

    always_comb begin
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.s2;
    assign rise  = st_r.s2 & ~st_r.s3;
    assign fall  = ~st_r.s2 & st_r.s3;
endmodule

/* File: part_timer.sv */
`timescale 1ns/100ps
// Summary of operation
// RULE_01 - Overflow interrupt asserted only while overflow enable and overflow flag are set.
// RULE_02 - Overflow flag set on FFh-to-reload pass; cleared by reading control/status.
// RULE_03 - Counter port reads live count; write loads counter without stopping it.
// RULE_04 - Every overflow reloads the counter with the reload value.
// RULE_05 - On overflow each PWM output takes its overflow level from inversion bit.
// RULE_06 - Reload value sets common period and resolution; zero gives full 8 bits.
// RULE_07 - Four output enable bits connect each PWM channel to its pin.
// RULE_08 - Not inverted: high while count at or below match, low above.
// RULE_09 - Changing an inversion bit flips that output immediately.
// RULE_10 - Per-channel duty register sets second edge; reload sets common first edge.
// RULE_11 - Snapshot edge select: 0 falling edge, 1 rising edge.
// RULE_12 - Per-channel snapshot interrupt enable gates its flag onto a request.
// RULE_13 - Snapshot flag set on snapshot; cleared by reading that result register.
// RULE_14 - Snapshot result takes counter on selected edge; writes are ignored.
// RULE_15 - Two upper snapshot control bits always read zero.
// RULE_16 - Reset clears every register of the timer to zero.
// RULE_17 - Force reload is write-only, reads zero, loads reload, clears prescaler.
// RULE_18 - Hidden match registers copied from duty registers at each overflow.
// RULE_19 - When counter reaches match, output returns to its pre-overflow level.
// RULE_20 - Prescaler divides chosen clock by two to the field value, 1 to 128.
// RULE_21 - Running counter increments each prescaled tick; from FFh is overflow.
module part_timer (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic       ext_clk_pin,
    input  wire logic [1:0] snap_input_pin,
    output logic      [7:0] rdata,
    output logic      [3:0] pwm_out_pin,
    output logic      [3:0] pwm_out_oe,
    output logic            overflow_irq,
    output logic      [1:0] snap_irq
);
    typedef struct packed {
        logic [3:0][7:0] duty_bits;
        logic [3:0][7:0] match_register;
        logic [3:0]      pwm_en;
        logic [3:0]      pwm_invert;
        logic [3:0]      pwm_raw;
        logic            clock_source_sel;
        logic [2:0]      prescale_div_sel;
        logic            count_run;
        logic            overflow_irq_en;
        logic            overflow_flag;
        logic [7:0]      live_count_bits;
        logic [7:0]      reload_bits;
        logic [1:0]      snap_edge;
        logic [1:0]      snap_irq_en;
        logic [1:0]      snap_flag;
        logic [1:0][7:0] snap_bits;
        logic [7:0]      rdata;
        logic [3:0]      pwm_out_pin;
        logic [3:0]      pwm_out_oe;
        logic            overflow_irq;
        logic [1:0]      snap_irq;
    } part_timer_type;

    part_timer_type st_r;
    part_timer_type st_nxt;

    logic       ext_level;
    logic       ext_rise;
    logic [1:0] snap_level;
    logic [1:0] snap_rise;
    logic [1:0] snap_fall;
    logic       src_tick;
    logic       cnt_tick;
    logic       force_wr;
    logic       cnt_wr;
    logic       ovf_evt;
    logic [7:0] cnt_cur;

    // Duty registers sit at descending addresses: channel 0 is highest
    function automatic logic [1:0] duty_index(input logic [7:0] a);
        return 2'(part_pkg::ADDR_DUTY_0 - a);
    endfunction

    function automatic logic is_duty(input logic [7:0] a);
        return (a >= part_pkg::ADDR_DUTY_3) && (a <= part_pkg::ADDR_DUTY_0);
    endfunction

    part_edge_sync u_ext_sync (
        .clock (clock),
        .rst_n (rst_n),
        .pin   (ext_clk_pin),
        .level (ext_level),
        .rise  (ext_rise),
        .fall  ()
    );

    for (genvar g = 0; g < 2; g++) begin : g_snap_sync
        part_edge_sync u_snap_sync (
            .clock (clock),
            .rst_n (rst_n),
            .pin   (snap_input_pin[g]),
            .level (snap_level[g]),
            .rise  (snap_rise[g]),
            .fall  (snap_fall[g])
        );
    end

    // External source counted on its rising edge, so it must run below clock/2
    assign src_tick = st_r.clock_source_sel ? ext_rise : 1'b1;
    assign force_wr = wr_en && (addr == part_pkg::ADDR_CTRL_STATUS) && wdata[part_pkg::CS_FORCE];
    assign cnt_wr   = wr_en && (addr == part_pkg::ADDR_COUNT_PORT);

    part_prescaler u_prescaler (
        .clock    (clock),
        .rst_n    (rst_n),
        .tick_in  (src_tick),
        .run      (st_r.count_run),
        .clear    (force_wr || cnt_wr), // [RULE_17]
        .sel      (st_r.prescale_div_sel),
        .tick_out (cnt_tick)
    );

    assign cnt_cur = st_r.live_count_bits;
    // [RULE_21]
    assign ovf_evt = cnt_tick && (cnt_cur == part_pkg::COUNT_TOP) && !cnt_wr && !force_wr;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;

        // Counter: software load wins over counting, overflow reloads
        if (cnt_wr) begin
            st_nxt.live_count_bits = wdata; // [RULE_03]
        end else if (force_wr) begin
            st_nxt.live_count_bits = st_r.reload_bits; // [RULE_17]
        end else if (ovf_evt) begin
            st_nxt.live_count_bits = st_r.reload_bits; // [RULE_04] [RULE_06]
        end else if (cnt_tick) begin
            st_nxt.live_count_bits = 8'(cnt_cur + 8'h01); // [RULE_21]
        end

        // PWM waveform: raw level is the non-inverted shape
        for (int i = 0; i < 4; i++) begin
            if (ovf_evt) begin
                st_nxt.match_register[i] = st_r.duty_bits[i]; // [RULE_18] [RULE_10]
                st_nxt.pwm_raw[i] = 1'b1; // [RULE_05]
            end else if (cnt_tick && cnt_cur == st_r.match_register[i]) begin
                st_nxt.pwm_raw[i] = 1'b0; // [RULE_19] [RULE_08]
            end
        end

        // Snapshot: inhibited while the previous result is unread
        for (int c = 0; c < 2; c++) begin
            if ((st_r.snap_edge[c] ? snap_rise[c] : snap_fall[c]) && !st_r.snap_flag[c]) begin
                st_nxt.snap_bits[c] = cnt_cur; // [RULE_11] [RULE_14]
                st_nxt.snap_flag[c] = 1'b1; // [RULE_13]
            end else if (rd_en && addr == 8'(part_pkg::ADDR_SNAP_1 + 8'(c))) begin
                st_nxt.snap_flag[c] = 1'b0; // [RULE_13]
            end
        end

        // Overflow flag: set beats the read-clear
        if (ovf_evt) begin
            st_nxt.overflow_flag = 1'b1; // [RULE_02]
        end else if (rd_en && addr == part_pkg::ADDR_CTRL_STATUS) begin
            st_nxt.overflow_flag = 1'b0; // [RULE_02]
        end

        if (wr_en) begin
            if (is_duty(addr)) begin
                st_nxt.duty_bits[duty_index(addr)] = wdata;
            end else if (addr == part_pkg::ADDR_OUT_CONTROL) begin
                st_nxt.pwm_en     = wdata[part_pkg::OC_EN_LSB +: 4];
                st_nxt.pwm_invert = wdata[part_pkg::OC_INV_LSB +: 4];
            end else if (addr == part_pkg::ADDR_CTRL_STATUS) begin
                st_nxt.clock_source_sel = wdata[part_pkg::CS_CLK_SEL];
                st_nxt.prescale_div_sel = wdata[part_pkg::CS_DIV_LSB +: 3];
                st_nxt.count_run        = wdata[part_pkg::CS_RUN];
                st_nxt.overflow_irq_en  = wdata[part_pkg::CS_OVF_IE];
            end else if (addr == part_pkg::ADDR_RELOAD) begin
                st_nxt.reload_bits = wdata;
            end else if (addr == part_pkg::ADDR_SNAP_CS) begin
                st_nxt.snap_edge   = wdata[part_pkg::SC_EDGE_LSB +: 2];
                st_nxt.snap_irq_en = wdata[part_pkg::SC_IE_LSB +: 2];
            end
            // Snapshot result writes fall through untouched [RULE_14]
        end

        if (rd_en) begin
            if (is_duty(addr)) begin
                st_nxt.rdata = st_r.duty_bits[duty_index(addr)];
            end else if (addr == part_pkg::ADDR_OUT_CONTROL) begin
                st_nxt.rdata = {st_r.pwm_en, st_r.pwm_invert};
            end else if (addr == part_pkg::ADDR_CTRL_STATUS) begin
                st_nxt.rdata = {st_r.clock_source_sel, st_r.prescale_div_sel, st_r.count_run,
                                1'b0, st_r.overflow_irq_en, st_r.overflow_flag}; // [RULE_17]
            end else if (addr == part_pkg::ADDR_COUNT_PORT) begin
                st_nxt.rdata = cnt_cur; // [RULE_03]
            end else if (addr == part_pkg::ADDR_RELOAD) begin
                st_nxt.rdata = st_r.reload_bits;
            end else if (addr == part_pkg::ADDR_SNAP_CS) begin
                st_nxt.rdata = {2'b00, st_r.snap_edge, st_r.snap_irq_en, st_r.snap_flag}; // [RULE_15]
            end else if (addr == part_pkg::ADDR_SNAP_1) begin
                st_nxt.rdata = st_r.snap_bits[0];
            end else if (addr == part_pkg::ADDR_SNAP_2) begin
                st_nxt.rdata = st_r.snap_bits[1];
            end
        end

        // Pin levels follow the next state so inversion acts on the next edge
        for (int i = 0; i < 4; i++) begin
            // [RULE_09] [RULE_08]
            st_nxt.pwm_out_pin[i] = st_nxt.pwm_en[i] &
                                    (st_nxt.pwm_raw[i] ^ st_nxt.pwm_invert[i]);
            st_nxt.pwm_out_oe[i]  = st_nxt.pwm_en[i]; // [RULE_07]
        end
        st_nxt.overflow_irq = st_nxt.overflow_irq_en & st_nxt.overflow_flag; // [RULE_01]
        st_nxt.snap_irq     = st_nxt.snap_irq_en & st_nxt.snap_flag; // [RULE_12]
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0; // [RULE_16]
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata        = st_r.rdata;
    assign pwm_out_pin  = st_r.pwm_out_pin;
    assign pwm_out_oe   = st_r.pwm_out_oe;
    assign overflow_irq = st_r.overflow_irq;
    assign snap_irq     = st_r.snap_irq;

    AST_IRQ_MASK: assert property (@(posedge clock) disable iff (!rst_n)
        overflow_irq |-> (st_r.overflow_irq_en && st_r.overflow_flag)) // [RULE_01]
        else $error("Overflow request without enable and flag");

    AST_OVF_SET: assert property (@(posedge clock) disable iff (!rst_n)
        ovf_evt |=> st_r.overflow_flag) // [RULE_02]
        else $error("Overflow flag not set on overflow");

    AST_OVF_CLR: assert property (@(posedge clock) disable iff (!rst_n)
        (rd_en && addr == part_pkg::ADDR_CTRL_STATUS && !ovf_evt) |=> !st_r.overflow_flag)
        else $error("Overflow flag survived status read"); // [RULE_02]

    AST_CNT_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
        cnt_wr |=> (st_r.live_count_bits == $past(wdata))) // [RULE_03]
        else $error("Counter write not loaded");

    AST_RELOAD: assert property (@(posedge clock) disable iff (!rst_n)
        ovf_evt |=> (st_r.live_count_bits == $past(st_r.reload_bits))) // [RULE_04]
        else $error("Counter not reloaded on overflow");

    AST_PWM_OVF: assert property (@(posedge clock) disable iff (!rst_n)
        (ovf_evt && st_nxt.pwm_en[0]) |=> (pwm_out_pin[0] == !st_r.pwm_invert[0])) // [RULE_05]
        else $error("Channel 0 wrong level after overflow");

    AST_OE: assert property (@(posedge clock) disable iff (!rst_n)
        !st_nxt.pwm_en[1] |=> (!pwm_out_pin[1] && !pwm_out_oe[1])) // [RULE_07]
        else $error("Disabled channel still drives");

    AST_SNAP: assert property (@(posedge clock) disable iff (!rst_n)
        (st_r.snap_edge[0] && snap_rise[0] && !st_r.snap_flag[0])
        |=> (st_r.snap_flag[0] && st_r.snap_bits[0] == $past(cnt_cur))) // [RULE_14]
        else $error("Snapshot 0 missed its rising edge");

    AST_SNAP_RSV: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rd_en && addr == part_pkg::ADDR_SNAP_CS) |-> (rdata[7:6] == 2'b00)) // [RULE_15]
        else $error("Reserved snapshot bits read non-zero");

    AST_MATCH: assert property (@(posedge clock) disable iff (!rst_n)
        ovf_evt |=> (st_r.match_register[2] == $past(st_r.duty_bits[2]))) // [RULE_18]
        else $error("Match register not copied at overflow");
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    logic       clock;
    logic       rst_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr_en;
    logic       rd_en;
    logic       ext_clk_pin;
    logic [1:0] snap_input_pin;
    logic [7:0] rdata;
    logic [3:0] pwm_out_pin;
    logic [3:0] pwm_out_oe;
    logic       overflow_irq;
    logic [1:0] snap_irq;
    int         fails;
    int         compares;
    int         cycles = 0;
    logic [7:0] v;
    int         hi;
    int         per;

    part_timer dut (
        .clock          (clock),
        .rst_n          (rst_n),
        .addr           (addr),
        .wdata          (wdata),
        .wr_en          (wr_en),
        .rd_en          (rd_en),
        .ext_clk_pin    (ext_clk_pin),
        .snap_input_pin (snap_input_pin),
        .rdata          (rdata),
        .pwm_out_pin    (pwm_out_pin),
        .pwm_out_oe     (pwm_out_oe),
        .overflow_irq   (overflow_irq),
        .snap_irq       (snap_irq)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic summarize();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Generous ceiling; the whole sequence needs about 5000 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails = fails + 1;
            summarize();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    // Bounded wait for the requested level on one PWM pin
    task automatic wait_pin(input int ch, input logic lvl);
        int n;
        n = 0;
        while (pwm_out_pin[ch] !== lvl && n < 600) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    task automatic measure(input int ch, output int h, output int p);
        wait_pin(ch, 1'b0);
        wait_pin(ch, 1'b1);
        h = 0;
        p = 0;
        while (pwm_out_pin[ch] === 1'b1 && p < 600) begin
            @(posedge clock);
            #1;
            h++;
            p++;
        end
        while (pwm_out_pin[ch] !== 1'b1 && p < 600) begin
            @(posedge clock);
            #1;
            p++;
        end
    endtask

    initial begin
        logic [7:0] tbl [4];
        fails = 0;
        compares = 0;
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ext_clk_pin = 1'b0;
        snap_input_pin = 2'b10;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;

        for (int a = 8'h72; a <= 8'h7e; a++) begin
            rdchk(a[7:0], 8'h00);
        end
        check({4'h0, pwm_out_oe}, 8'h00);
        for (int a = 8'h73; a <= 8'h76; a++) begin
            wr(a[7:0], 8'ha5 ^ a[7:0]);
            rdchk(a[7:0], 8'ha5 ^ a[7:0]);
        end
        wr(part_pkg::ADDR_RELOAD, 8'h5c);
        rdchk(part_pkg::ADDR_RELOAD, 8'h5c);
        wr(8'h70, 8'hff);
        rdchk(8'h70, 8'h00);
        $display("Test registers done");

        // Force reload with the counter stopped
        wr(part_pkg::ADDR_CTRL_STATUS, 8'h04);
        rdchk(part_pkg::ADDR_COUNT_PORT, 8'h5c);
        rdchk(part_pkg::ADDR_CTRL_STATUS, 8'h00);
        wr(part_pkg::ADDR_COUNT_PORT, 8'hf0);
        rdchk(part_pkg::ADDR_COUNT_PORT, 8'hf0);
        $display("Test force reload done");

        // Prescaler: about eight ticks in 8 << sel cycles
        for (int s = 0; s < 8; s++) begin
            wr(part_pkg::ADDR_CTRL_STATUS, 8'(s << 4));
            wr(part_pkg::ADDR_COUNT_PORT, 8'h00);
            wr(part_pkg::ADDR_CTRL_STATUS, 8'(s << 4) | 8'h08);
            repeat (8 << s) @(posedge clock);
            rd(part_pkg::ADDR_COUNT_PORT, v);
            check({7'h0, v >= 8'h07 && v <= 8'h0a}, 8'h01);
        end
        $display("Test prescaler done");

        // External source: five rising edges give five counts
        wr(part_pkg::ADDR_CTRL_STATUS, 8'h80);
        wr(part_pkg::ADDR_COUNT_PORT, 8'h00);
        wr(part_pkg::ADDR_CTRL_STATUS, 8'h88);
        repeat (5) begin
            repeat (4) @(posedge clock);
            ext_clk_pin <= 1'b1;
            repeat (4) @(posedge clock);
            ext_clk_pin <= 1'b0;
        end
        repeat (6) @(posedge clock);
        rdchk(part_pkg::ADDR_COUNT_PORT, 8'h05);
        $display("Test external source done");

        // Overflow flag, request and reload
        wr(part_pkg::ADDR_CTRL_STATUS, 8'h00);
        wr(part_pkg::ADDR_RELOAD, 8'h10);
        wr(part_pkg::ADDR_COUNT_PORT, 8'hfe);
        check({7'h0, overflow_irq}, 8'h00);
        wr(part_pkg::ADDR_CTRL_STATUS, 8'h0a);
        for (int n = 0; n < 20 && overflow_irq !== 1'b1; n++) @(posedge clock);
        check({7'h0, overflow_irq}, 8'h01);
        rdchk(part_pkg::ADDR_CTRL_STATUS, 8'h0b);
        rdchk(part_pkg::ADDR_CTRL_STATUS, 8'h0a);
        check({7'h0, overflow_irq}, 8'h00);
        rd(part_pkg::ADDR_COUNT_PORT, v);
        check({7'h0, v >= 8'h10 && v < 8'h20}, 8'h01);
        wr(part_pkg::ADDR_CTRL_STATUS, 8'h08);
        repeat (260) @(posedge clock);
        check({7'h0, overflow_irq}, 8'h00);
        rdchk(part_pkg::ADDR_CTRL_STATUS, 8'h09);
        $display("Test overflow done");

        // PWM: reload, duty, expected high and period
        tbl = '{8'h80, 8'hc0, 8'h00, 8'h3f};
        for (int t = 0; t < 2; t++) begin
            wr(part_pkg::ADDR_CTRL_STATUS, 8'h00);
            wr(part_pkg::ADDR_RELOAD, tbl[2 * t]);
            wr(part_pkg::ADDR_DUTY_0, tbl[2 * t + 1]);
            wr(part_pkg::ADDR_DUTY_1, tbl[2 * t] + 8'h20);
            wr(part_pkg::ADDR_OUT_CONTROL, 8'h30);
            wr(part_pkg::ADDR_CTRL_STATUS, 8'h0c);
            measure(0, hi, per);
            check(8'(hi), tbl[2 * t + 1] - tbl[2 * t] + 8'h01);
            check(8'(per), 8'h00 - tbl[2 * t]);
            measure(1, hi, per);
            check(8'(hi), 8'h21);
            check({4'h0, pwm_out_oe}, 8'h03);
            check({4'h0, pwm_out_pin[3:2]}, 8'h00);
        end
        // Invert while high: pin drops without waiting for an event
        wait_pin(0, 1'b0);
        wait_pin(0, 1'b1);
        wr(part_pkg::ADDR_OUT_CONTROL, 8'h31);
        @(posedge clock);
        #1;
        check({7'h0, pwm_out_pin[0]}, 8'h00);
        measure(0, hi, per);
        check(8'(hi), 8'hc0);
        $display("Test PWM done");

        // Snapshot with the counter frozen at a known value
        wr(part_pkg::ADDR_CTRL_STATUS, 8'h00);
        wr(part_pkg::ADDR_OUT_CONTROL, 8'h00);
        wr(part_pkg::ADDR_COUNT_PORT, 8'h42);
        wr(part_pkg::ADDR_SNAP_CS, 8'h1c);
        @(posedge clock);
        snap_input_pin <= 2'b01;
        for (int n = 0; n < 12 && snap_irq !== 2'b11; n++) @(posedge clock);
        check({6'h0, snap_irq}, 8'h03);
        rdchk(part_pkg::ADDR_SNAP_CS, 8'h1f);
        wr(part_pkg::ADDR_COUNT_PORT, 8'h43);
        snap_input_pin <= 2'b00;
        repeat (4) @(posedge clock);
        snap_input_pin <= 2'b01;
        repeat (6) @(posedge clock);
        wr(part_pkg::ADDR_SNAP_1, 8'h99);
        rdchk(part_pkg::ADDR_SNAP_1, 8'h42);
        rdchk(part_pkg::ADDR_SNAP_2, 8'h42);
        rdchk(part_pkg::ADDR_SNAP_CS, 8'h1c);
        @(posedge clock);
        check({6'h0, snap_irq}, 8'h00);
        snap_input_pin <= 2'b00;
        repeat (6) @(posedge clock);
        rdchk(part_pkg::ADDR_SNAP_CS, 8'h1c);
        rdchk(part_pkg::ADDR_SNAP_1, 8'h42);
        wr(part_pkg::ADDR_SNAP_CS, 8'hff);
        rdchk(part_pkg::ADDR_SNAP_CS, 8'h3c);
        $display("Test snapshot done");
        summarize();
    end
endmodule
